// ===== include/pmr_pkg.sv
// Constants, types and decode helpers for the speed-control and receive-error register bank.
// Assumes one clock domain and a 16-bit management data path with 5-bit register addresses.
package pmr_pkg;

   localparam int          ADDR_W          = 5;
   localparam int          DATA_W          = 16;
   localparam int          CNT_W           = 16;
   localparam int          MODE_W          = 4;

   localparam logic [4:0]  OFS_EXT_CTRL    = 5'h14;
   localparam logic [4:0]  OFS_RX_ERR_CNT  = 5'h15;
   localparam logic [4:0]  OFS_IRQ_STATUS  = 5'h18;
   localparam logic [4:0]  OFS_IRQ_MASK    = 5'h19;
   localparam logic [4:0]  OFS_SOFT_RESET  = 5'h1A;

   localparam int          CTRL_LSB        = 0;
   localparam int          CTRL_MSB        = 6;
   localparam int          SOFT_RESET_BIT  = 0;

   localparam logic [2:0]  SPEED_RESET     = 3'h6;
   localparam logic [15:0] CNT_RESET       = 16'h0000;
   localparam logic [15:0] CNT_MAX         = 16'hFFFF;
   localparam logic [2:0]  IRQ_RESET       = 3'h0;

   localparam logic [3:0]  MODE_FIBER_A    = 4'h3;
   localparam logic [3:0]  MODE_FIBER_B    = 4'h7;
   localparam logic [3:0]  MODE_RGMII_SER  = 4'h6;
   localparam logic [3:0]  MODE_GMII_SER   = 4'hE;

   localparam int          IRQ_W           = 3;
   localparam int          IRQ_ERR_BIT     = 0;
   localparam int          IRQ_SAT_BIT     = 1;
   localparam int          IRQ_SWRST_BIT   = 2;

   typedef enum logic [1:0]
   {
      SPD_10   = 2'b00,
      SPD_100  = 2'b01,
      SPD_1000 = 2'b10
   } pmr_speed_e;

   typedef enum logic [1:0]
   {
      TXCLK_OFF = 2'b00,
      TXCLK_2M5 = 2'b01,
      TXCLK_25M = 2'b10
   } pmr_txclk_e;

   // Field layout of the low seven bits of the extended control register, MSB first.
   typedef struct packed
   {
      logic [2:0] speed;
      logic       rsvd3;
      logic       dte_en;
      logic       tx_delay;
      logic       rsvd0;
   } pmr_ctrl_s;

   typedef struct packed
   {
      logic false_carrier;
      logic symbol_error;
   } pmr_rxerr_s;

   localparam pmr_ctrl_s   CTRL_RESET      = '{speed: SPEED_RESET, default: 1'b0};

   // Codes 010 and 011 are not defined; they fall back to 10 Mbps.
   function automatic pmr_speed_e pmr_code_speed(input logic [2:0] code);
      pmr_speed_e s;
      s = SPD_10;
      if (code[2:1] == 2'b11)
      begin
         s = SPD_1000;
      end
      else if (code[1:0] == 2'b01)
      begin
         s = SPD_100;
      end
      return s;
   endfunction

   function automatic logic pmr_is_fiber_mode(input logic [3:0] mode);
      return (mode == MODE_FIBER_A) || (mode == MODE_FIBER_B) ||
             (mode == MODE_RGMII_SER) || (mode == MODE_GMII_SER);
   endfunction

   function automatic logic pmr_is_serial_mode(input logic [3:0] mode);
      return (mode == MODE_RGMII_SER) || (mode == MODE_GMII_SER);
   endfunction

endpackage

// ===== rtl/pmr_sync.sv
// Two-flop synchroniser for a bus of quasi-static levels such as strap pins.
// Assumes the bits change rarely; no coherence between bits is promised while they move.
`timescale 1ns/1ps
`default_nettype none
module pmr_sync
#(
   parameter int W = 4
)
(
   input  wire logic         clk,     // System clock.
   input  wire logic         reset_n, // Asynchronous reset, active low.
   input  wire logic [W-1:0] d_in,    // Asynchronous level input.
   output logic      [W-1:0] d_out    // Synchronised level.
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end

   assign d_out = sync_reg;

endmodule // pmr_sync
`default_nettype wire

// ===== rtl/pmr_rx_err_counter.sv
// Saturating receive error counter that adds up to two events per cycle.
// Assumes event inputs are single-cycle pulses on the system clock.
`timescale 1ns/1ps
`default_nettype none
module pmr_rx_err_counter
   import pmr_pkg::*;
#(
   parameter int W = CNT_W
)
(
   input  wire logic         clk,       // System clock.
   input  wire logic         reset_n,   // Hardware reset, active low.
   input  wire pmr_rxerr_s   events,    // Selected medium error pulses.
   output logic      [W-1:0] count,     // Current count.
   output logic              saturated  // Pulse when the count reaches its top.
);

   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic [W:0]   sum;

   always_comb
   begin
      sum = {1'b0, count_reg} + (W+1)'(events.false_carrier) + (W+1)'(events.symbol_error);
      if (sum[W])
      begin
         count_next = {W{1'b1}};
      end
      else
      begin
         count_next = sum[W-1:0];
      end
   end

   // Software reset is not wired here on purpose: only hardware reset may clear the count.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count_reg <= '0;
      end
      else
      begin
         count_reg <= count_next;
      end
   end

   assign count     = count_reg;
   assign saturated = (count_next == {W{1'b1}}) && (count_reg != {W{1'b1}});

endmodule // pmr_rx_err_counter
`default_nettype wire

// ===== rtl/pmr_regs.sv
// Extended speed control and receive error count registers behind a plain management port.
// Assumes link status and receive error pulses come from logic on clk; the mode strap comes from pins.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Speed field bits 6:4 resets to 110 and picks MAC speed during link down with copper auto-negotiation on.
// - A written speed takes effect only at the next software reset.
// - In serial gigabit modes without serial negotiation, bits 5:4 set link speed.
// - Code 000 means 10 Mbps, 2.5 MHz clock when down, none on gigabit link.
// - Code 001 means 100 Mbps with a 25 MHz clock while the link is down.
// - Code 110 means 1000 Mbps with a 2.5 MHz clock while the link is down.
// - Bit 2 enables DTE detection; it resets to zero.
// - Bit 1 delays the gigabit transmit clock, resets zero, applied at software reset.
// - The error counter stops at FFFF and never wraps.
// - False carrier and symbol errors both count.
// - Modes 0011, 0111, 0110 and 1110 count fiber-side errors.
// - All other modes count copper-side errors.
// - Counter is read-only, cleared by hardware reset, kept over software reset.
// - Mode 0110 is RGMII to serial and 1110 is GMII to serial gigabit.
module pmr_regs
   import pmr_pkg::*;
(
   input  wire logic              clk,                 // 200 MHz system clock.
   input  wire logic              reset_n,             // Hardware reset, active low.
   input  wire logic [ADDR_W-1:0] reg_addr,            // Register address.
   input  wire logic [DATA_W-1:0] reg_wdata,           // Write data.
   input  wire logic              reg_write,           // Write strobe.
   input  wire logic              reg_read,            // Read strobe.
   output logic      [DATA_W-1:0] reg_rdata,           // Read data, valid the cycle after the strobe.
   input  wire logic [MODE_W-1:0] hw_mode_pin,         // Hardware mode strap pins.
   input  wire logic              link_up,             // Link is up.
   input  wire pmr_speed_e        link_speed,          // Resolved speed while the link is up.
   input  wire logic              link_is_1000t,       // The up link is copper 1000BASE-T.
   input  wire logic              autoneg_en,          // Copper auto-negotiation enabled.
   input  wire logic              serial_aneg_en,      // Serial auto-negotiation enabled.
   input  wire pmr_rxerr_s        copper_err,          // Copper receive error pulses.
   input  wire pmr_rxerr_s        fiber_err,           // Fiber receive error pulses.
   output pmr_speed_e             mac_speed,           // Speed of the MAC interface.
   output pmr_txclk_e             mac_txclk_rate,      // Rate of the MAC transmit clock.
   output pmr_speed_e             serial_speed,        // Forced serial link speed.
   output logic                   serial_speed_forced, // Serial speed is forced by the register.
   output logic                   dte_detect_en,       // DTE detection enabled.
   output logic                   gigabit_transmit_clock_delay, // Delay gigabit transmit clock.
   output logic                   soft_reset_pulse,    // One-cycle software reset.
   output logic                   irq                  // Level interrupt.
);

   pmr_ctrl_s          ctrl_reg;
   logic [2:0]         active_speed_reg;
   logic               active_delay_reg;
   logic               swrst_reg;
   logic [IRQ_W-1:0]   irq_status_reg;
   logic [IRQ_W-1:0]   irq_status_next;
   logic [IRQ_W-1:0]   irq_mask_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic [DATA_W-1:0]  rdata_next;
   logic [MODE_W-1:0]  hw_mode;
   logic [CNT_W-1:0]   err_count;
   logic               err_saturated;
   logic               fiber_mode;
   pmr_rxerr_s         sel_err;
   pmr_speed_e         default_speed;
   logic [IRQ_W-1:0]   irq_events;

   function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
      return reg_write && (reg_addr == ofs);
   endfunction

   pmr_sync #(.W(MODE_W)) u_mode_sync
   (
      .clk     (clk),
      .reset_n (reset_n),
      .d_in    (hw_mode_pin),
      .d_out   (hw_mode)
   );

   assign fiber_mode = pmr_is_fiber_mode(hw_mode);
   assign sel_err    = fiber_mode ? fiber_err : copper_err;

   pmr_rx_err_counter #(.W(CNT_W)) u_err_cnt
   (
      .clk       (clk),
      .reset_n   (reset_n),
      .events    (sel_err),
      .count     (err_count),
      .saturated (err_saturated)
   );

   // Reserved bits are stored as written so that a read-modify-write returns them intact.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctrl_reg <= CTRL_RESET;
      end
      else if (wr_hit(OFS_EXT_CTRL))
      begin
         ctrl_reg <= reg_wdata[CTRL_MSB:CTRL_LSB];
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         swrst_reg <= 1'b0;
      end
      else
      begin
         swrst_reg <= wr_hit(OFS_SOFT_RESET) && reg_wdata[SOFT_RESET_BIT];
      end
   end

   // Speed and transmit delay disturb a running link, so they only move at a software reset.
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         active_speed_reg <= SPEED_RESET;
         active_delay_reg <= 1'b0;
      end
      else if (swrst_reg)
      begin
         active_speed_reg <= ctrl_reg.speed;
         active_delay_reg <= ctrl_reg.tx_delay;
      end
   end

   assign default_speed = pmr_code_speed(active_speed_reg);

   always_comb
   begin
      mac_speed      = link_speed;
      mac_txclk_rate = TXCLK_2M5;
      if (!link_up && autoneg_en)
      begin
         mac_speed = default_speed;
         if (active_speed_reg == 3'b001)
         begin
            mac_txclk_rate = TXCLK_25M;
         end
      end
      else if (link_up && link_is_1000t)
      begin
         mac_txclk_rate = active_speed_reg[2] ? TXCLK_2M5 : TXCLK_OFF;
      end
      else if (link_speed == SPD_100)
      begin
         mac_txclk_rate = TXCLK_25M;
      end
   end

   // Only bits 5:4 matter here: 00 is 10, 01 is 100, 1x is 1000 Mbps.
   always_comb
   begin
      serial_speed = SPD_10;
      if (active_speed_reg[1])
      begin
         serial_speed = SPD_1000;
      end
      else if (active_speed_reg[0])
      begin
         serial_speed = SPD_100;
      end
   end

   assign serial_speed_forced          = pmr_is_serial_mode(hw_mode) && !serial_aneg_en;
   assign dte_detect_en                = ctrl_reg.dte_en;
   assign gigabit_transmit_clock_delay = active_delay_reg;
   assign soft_reset_pulse             = swrst_reg;

   assign irq_events = {swrst_reg, err_saturated, |sel_err};

   always_comb
   begin
      irq_status_next = irq_status_reg;
      if (wr_hit(OFS_IRQ_STATUS))
      begin
         irq_status_next = irq_status_next & ~reg_wdata[IRQ_W-1:0];
      end
      // Setting after the clear keeps an event that lands in the clearing cycle.
      irq_status_next = irq_status_next | irq_events;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_status_reg <= IRQ_RESET;
         irq_mask_reg   <= IRQ_RESET;
      end
      else
      begin
         irq_status_reg <= irq_status_next;
         if (wr_hit(OFS_IRQ_MASK))
         begin
            irq_mask_reg <= reg_wdata[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   always_comb
   begin
      rdata_next = '0;
      unique case (reg_addr)
         OFS_EXT_CTRL:   rdata_next[CTRL_MSB:CTRL_LSB] = ctrl_reg;
         OFS_RX_ERR_CNT: rdata_next = err_count;
         OFS_IRQ_STATUS: rdata_next[IRQ_W-1:0] = irq_status_reg;
         OFS_IRQ_MASK:   rdata_next[IRQ_W-1:0] = irq_mask_reg;
         default:        rdata_next = '0;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rdata_reg <= '0;
      end
      else
      begin
         rdata_reg <= reg_read ? rdata_next : '0;
      end
   end

   assign reg_rdata = rdata_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_speed_written;
      wr_hit(OFS_EXT_CTRL) ##1 !swrst_reg;
   endsequence

   sequence s_soft_reset;
      wr_hit(OFS_SOFT_RESET) && reg_wdata[SOFT_RESET_BIT] ##1 swrst_reg;
   endsequence

   a_speed_waits_reset: assert property (s_speed_written |-> $stable(active_speed_reg))
      else $error("Written speed applied without a software reset.");

   a_speed_applies: assert property (s_soft_reset |=> active_speed_reg == $past(ctrl_reg.speed))
      else $error("Software reset did not apply the stored speed.");

   a_ctrl_readback: assert property (reg_read && reg_addr == OFS_EXT_CTRL
                                     |=> reg_rdata == {9'h000, $past(ctrl_reg)})
      else $error("Control register read back wrong value.");

   a_reserved_kept: assert property (wr_hit(OFS_EXT_CTRL)
                                     |=> {ctrl_reg.rsvd3, ctrl_reg.rsvd0}
                                         == {$past(reg_wdata[3]), $past(reg_wdata[0])})
      else $error("Reserved control bits not stored as written.");

   a_clk_10_down: assert property (!link_up && autoneg_en && active_speed_reg == 3'b000
                                   |-> mac_speed == SPD_10 && mac_txclk_rate == TXCLK_2M5)
      else $error("Code 000 link-down speed or clock wrong.");

   a_clk_10_gig: assert property (link_up && link_is_1000t && active_speed_reg == 3'b000
                                  |-> mac_txclk_rate == TXCLK_OFF)
      else $error("Code 000 clock not stopped on gigabit link.");

   a_clk_100_down: assert property (!link_up && autoneg_en && active_speed_reg == 3'b001
                                    |-> mac_speed == SPD_100 && mac_txclk_rate == TXCLK_25M)
      else $error("Code 001 link-down speed or clock wrong.");

   a_clk_1000_down: assert property (!link_up && autoneg_en && active_speed_reg == 3'b110
                                     |-> mac_speed == SPD_1000 && mac_txclk_rate == TXCLK_2M5)
      else $error("Code 110 link-down speed or clock wrong.");

   a_serial_forced: assert property (serial_speed_forced
                                     |-> (hw_mode == MODE_RGMII_SER || hw_mode == MODE_GMII_SER)
                                     && serial_speed == (active_speed_reg[1] ? SPD_1000 :
                                        active_speed_reg[0] ? SPD_100 : SPD_10))
      else $error("Forced serial speed does not follow bits 5:4.");

   a_dte_follows: assert property (wr_hit(OFS_EXT_CTRL) |=> dte_detect_en == $past(reg_wdata[2]))
      else $error("DTE enable does not follow the written bit.");

   a_delay_applies: assert property (s_soft_reset |=> gigabit_transmit_clock_delay == $past(ctrl_reg.tx_delay))
      else $error("Transmit clock delay not applied at software reset.");

   a_count_pegs: assert property (err_count == CNT_MAX |=> err_count == CNT_MAX)
      else $error("Error counter left its maximum.");

   a_count_step: assert property (err_count < 16'hFFFE |=> err_count == $past(err_count)
                                  + 16'($past(sel_err.false_carrier)) + 16'($past(sel_err.symbol_error)))
      else $error("Error counter did not step by the event count.");

   a_fiber_counts: assert property (fiber_mode && fiber_err.symbol_error && err_count < CNT_MAX
                                    |=> err_count != $past(err_count))
      else $error("Fiber error not counted in a fiber mode.");

   a_copper_counts: assert property (!fiber_mode && copper_err == '0 && fiber_err != '0
                                     |=> $stable(err_count))
      else $error("Fiber error counted in a copper mode.");

   a_count_swrst: assert property (swrst_reg && sel_err == '0 |=> $stable(err_count))
      else $error("Software reset disturbed the error counter.");

endmodule // pmr_regs
`default_nettype wire

// ===== bench/pmr_link_model.sv
// Behavioural model of the data side: link state, mode straps and receive error pulses.
// Assumes it shares clk with the register bank and is steered by the bench through its tasks.
`timescale 1ns/1ps
`default_nettype none
module pmr_link_model
   import pmr_pkg::*;
(
   input  wire logic              clk,            // System clock.
   output logic      [MODE_W-1:0] hw_mode_pin,    // Mode strap level.
   output logic                   link_up,        // Link status.
   output pmr_speed_e             link_speed,     // Resolved link speed.
   output logic                   link_is_1000t,  // Up link is gigabit copper.
   output logic                   autoneg_en,     // Copper negotiation on.
   output logic                   serial_aneg_en, // Serial negotiation on.
   output pmr_rxerr_s             copper_err,     // Copper error pulses.
   output pmr_rxerr_s             fiber_err       // Fiber error pulses.
);
   initial
   begin
      hw_mode_pin = 4'h0;
      link_up = 1'h0;
      link_speed = SPD_10;
      link_is_1000t = 1'h0;
      autoneg_en = 1'h1;
      serial_aneg_en = 1'h0;
      copper_err = '0;
      fiber_err = '0;
   end

   task automatic set_link(input logic up, input pmr_speed_e s, input logic t);
      @(posedge clk);
      link_up <= up;
      link_speed <= s;
      link_is_1000t <= t;
   endtask

   // Straps pass a two-flop synchroniser, so settle three edges before returning.
   task automatic set_mode(input logic [3:0] m);
      @(posedge clk);
      hw_mode_pin <= m;
      repeat (3) @(posedge clk);
      #1;
   endtask

   // Negotiation enables are levels on clk; outputs are settled when this returns.
   task automatic set_aneg(input logic cu, input logic ser);
      @(posedge clk);
      autoneg_en <= cu;
      serial_aneg_en <= ser;
      #1;
   endtask

   // Holds the error fields for n cycles on one medium; the other medium stays quiet.
   task automatic errs(input logic fib, input pmr_rxerr_s e, input int n);
      @(posedge clk);
      copper_err <= fib ? 2'h0 : e;
      fiber_err <= fib ? e : 2'h0;
      repeat (n) @(posedge clk);
      copper_err <= '0;
      fiber_err <= '0;
      #1;
   endtask
endmodule // pmr_link_model
`default_nettype wire

// ===== bench/phy_mac_speed_rx_error_regs_tb.sv
// Self-checking bench for the speed control and receive error register bank.
// Assumes the link model drives all data-side inputs and the bench owns the register port.
`timescale 1ns/1ps
`default_nettype none
module phy_mac_speed_rx_error_regs_tb;
   import pmr_pkg::*;
   logic              clk = 1'h0;
   logic              reset_n = 1'h0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic              reg_write = 1'h0;
   logic              reg_read = 1'h0;
   logic [DATA_W-1:0] reg_rdata;
   logic [MODE_W-1:0] hw_mode_pin;
   logic              link_up, link_is_1000t, autoneg_en, serial_aneg_en;
   pmr_speed_e        link_speed, mac_speed, serial_speed;
   pmr_rxerr_s        copper_err, fiber_err;
   pmr_txclk_e        mac_txclk_rate;
   logic              serial_speed_forced, dte_detect_en, gig_delay, soft_reset_pulse, irq;
   int                err_count = 0;
   int                checks_done = 0;
   int                exp_cnt = 0;
   logic [3:0]        modes [6] = '{4'h0, 4'h3, 4'h7, 4'h6, 4'hE, 4'h9};
   logic              fib;

   always #2.5 clk = ~clk;

   pmr_link_model lm (.clk(clk), .hw_mode_pin(hw_mode_pin), .link_up(link_up), .link_speed(link_speed),
      .link_is_1000t(link_is_1000t), .autoneg_en(autoneg_en), .serial_aneg_en(serial_aneg_en),
      .copper_err(copper_err), .fiber_err(fiber_err));

   pmr_regs dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .hw_mode_pin(hw_mode_pin),
      .link_up(link_up), .link_speed(link_speed), .link_is_1000t(link_is_1000t), .autoneg_en(autoneg_en),
      .serial_aneg_en(serial_aneg_en), .copper_err(copper_err), .fiber_err(fiber_err),
      .mac_speed(mac_speed), .mac_txclk_rate(mac_txclk_rate), .serial_speed(serial_speed),
      .serial_speed_forced(serial_speed_forced), .dte_detect_en(dte_detect_en),
      .gigabit_transmit_clock_delay(gig_delay), .soft_reset_pulse(soft_reset_pulse), .irq(irq));

   task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t output %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'h1;
      @(posedge clk);
      reg_write <= 1'h0;
      #1;
   endtask

   // Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
   task automatic chk_reg(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'h1;
      @(posedge clk);
      reg_read <= 1'h0;
      #1;
      checks_done++;
      if (reg_rdata !== exp)
      begin
         err_count++;
         $display("[ERR] %0t read %h got %h expected %h", $time, a, reg_rdata, exp);
      end
   endtask

   task automatic sreset;
      wr(OFS_SOFT_RESET, 16'h0001);
      chk_pin(16'(soft_reset_pulse), 16'h0001);
      repeat (2) @(posedge clk);
      #1;
      chk_pin(16'(soft_reset_pulse), 16'h0000);
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
      begin
         $display("ALL TESTS PASSED");
      end
      else
      begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // The saturation burst dominates the run at about 33k cycles.
   initial
   begin
      #250000;
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge clk);
      chk_reg(OFS_EXT_CTRL, 16'h0060);
      chk_reg(OFS_RX_ERR_CNT, 16'h0000);
      chk_reg(5'h1F, 16'h0000);
      chk_pin(16'(mac_speed), 16'(SPD_1000));
      chk_pin(16'(mac_txclk_rate), 16'(TXCLK_2M5));
      chk_pin(16'(gig_delay), 16'h0000);
      wr(OFS_EXT_CTRL, 16'h0016);
      chk_pin(16'(dte_detect_en), 16'h0001);
      chk_pin(16'(mac_speed), 16'(SPD_1000));
      chk_pin(16'(gig_delay), 16'h0000);
      chk_reg(OFS_EXT_CTRL, 16'h0016);
      sreset();
      chk_pin(16'(mac_speed), 16'(SPD_100));
      chk_pin(16'(mac_txclk_rate), 16'(TXCLK_25M));
      chk_pin(16'(gig_delay), 16'h0001);
      chk_reg(OFS_IRQ_STATUS, 16'h0004);
      chk_pin(16'(irq), 16'h0000);
      wr(OFS_IRQ_MASK, 16'h0007);
      chk_pin(16'(irq), 16'h0001);
      wr(OFS_IRQ_STATUS, 16'h0004);
      chk_pin(16'(irq), 16'h0000);
      for (int i = 3; i < 5; i++)
      begin
         lm.set_mode(modes[i]);
         chk_pin(16'(serial_speed_forced), 16'h0001);
         chk_pin(16'(serial_speed), 16'(SPD_100));
      end
      lm.set_aneg(1'h0, 1'h1);
      chk_pin(16'(serial_speed_forced), 16'h0000);
      chk_pin(16'(mac_speed), 16'(SPD_10));
      lm.set_aneg(1'h1, 1'h0);
      wr(OFS_EXT_CTRL, 16'h0000);
      sreset();
      chk_pin(16'(mac_speed), 16'(SPD_10));
      chk_pin(16'(mac_txclk_rate), 16'(TXCLK_2M5));
      lm.set_link(1'h1, SPD_1000, 1'h1);
      #1;
      chk_pin(16'(mac_txclk_rate), 16'(TXCLK_OFF));
      chk_pin(16'(mac_speed), 16'(SPD_1000));
      lm.set_link(1'h0, SPD_10, 1'h0);
      foreach (modes[i])
      begin
         lm.set_mode(modes[i]);
         fib = (modes[i] == 4'h3) || (modes[i] == 4'h7) || (modes[i] == 4'h6) || (modes[i] == 4'hE);
         lm.errs(1'h1, 2'h2, 1);
         lm.errs(1'h0, 2'h1, 1);
         exp_cnt++;
         chk_reg(OFS_RX_ERR_CNT, 16'(exp_cnt));
         lm.errs(fib, 2'h3, 2);
         exp_cnt += 4;
         chk_reg(OFS_RX_ERR_CNT, 16'(exp_cnt));
      end
      wr(OFS_RX_ERR_CNT, 16'h1234);
      sreset();
      chk_reg(OFS_RX_ERR_CNT, 16'(exp_cnt));
      lm.errs(1'h0, 2'h3, (65535 - exp_cnt) / 2 - 1);
      exp_cnt += 2 * ((65535 - exp_cnt) / 2 - 1);
      chk_reg(OFS_RX_ERR_CNT, 16'(exp_cnt));
      repeat (5)
      begin
         lm.errs(1'h0, 2'h1, 1);
         exp_cnt = (exp_cnt < 65535) ? exp_cnt + 1 : 65535;
         chk_reg(OFS_RX_ERR_CNT, 16'(exp_cnt));
      end
      lm.errs(1'h0, 2'h3, 1);
      chk_reg(OFS_RX_ERR_CNT, 16'hFFFF);
      chk_reg(OFS_IRQ_STATUS, 16'h0007);
      chk_pin(16'(irq), 16'h0001);
      wr(OFS_IRQ_MASK, 16'h0000);
      chk_pin(16'(irq), 16'h0000);
      wr(OFS_IRQ_STATUS, 16'h0007);
      chk_reg(OFS_IRQ_STATUS, 16'h0000);
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge clk);
      chk_reg(OFS_RX_ERR_CNT, 16'h0000);
      chk_reg(OFS_EXT_CTRL, 16'h0060);
      tally_and_finish();
   end
endmodule // phy_mac_speed_rx_error_regs_tb
`default_nettype wire
